/* ppar_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ppar_core_model (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // stack pointer and address stack
    input  wire logic        SP_DEC,
    input  wire logic        SP_INC,
    input  wire logic        STK_WR,
    input  wire logic [2:0]  STK_IDX,
    input  wire logic [15:0] STK_WDATA,
    output logic      [15:0] STK_RDATA,
    output logic      [2:0]  SP,
    // program memory
    input  wire logic [15:0] PM_ADDR,
    output logic      [15:0] PM_RDATA
);
    logic [2:0]  sp_ff;
    logic [15:0] stk_ff [8];
    // ------------------------------------------------------------
    // far side reads
    // ------------------------------------------------------------
    // table words scramble the address so a wrong fetch shows up
    assign PM_RDATA  = PM_ADDR ^ 16'ha5c3;
    assign STK_RDATA = stk_ff[STK_IDX];
    assign SP        = sp_ff;
    // stack pointer moves only on the block's strobes
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sp_ff <= 3'h0;
        end else begin
            sp_ff <= sp_ff - {2'h0, SP_DEC} + {2'h0, SP_INC};
            if (STK_WR) begin
                stk_ff[STK_IDX] <= STK_WDATA;
            end
        end
    end
endmodule
`default_nettype wire

/* ppar_pkg.sv */
// Operation
// - pointer is sixteen bits from four nibbles at 74h-77h, 74h most significant
// - system register map spans 74h-7fh with window, bank, index, pointer, status
// - all pointer nibbles clear on power-on, watchdog/stack and chip-enable reset
// - clock-stop instruction leaves the pointer unchanged
// - table read fetches the sixteen-bit word at the pointer into the data buffer
// - table reads, branches and calls target only implemented program memory
// - push decrements stack pointer, then writes pointer at the new entry
// - pop copies entry at current stack pointer, then increments stack pointer
// - indirect branch loads program counter from the pointer
// - indirect call starts a subroutine at the pointer address
// - increment adds one to the whole sixteen-bit pointer, carry across nibbles
// - pointer exchanges data with peripherals through the data buffer
// - system registers appear at 74h-7fh in every bank alike
// - data buffer sits at 0ch-0fh of bank 0
`default_nettype none
package ppar_pkg;
    // ------------------------------------------------------------------
    // data memory map
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_PTR_TOP    = 7'h74;
    localparam logic [6:0] ADDR_PTR_UPPER  = 7'h75;
    localparam logic [6:0] ADDR_PTR_LOWER  = 7'h76;
    localparam logic [6:0] ADDR_PTR_BOTTOM = 7'h77;
    localparam logic [6:0] ADDR_WINDOW     = 7'h78;
    localparam logic [6:0] ADDR_BANK       = 7'h79;
    localparam logic [6:0] ADDR_IDX_HIGH   = 7'h7a;
    localparam logic [6:0] ADDR_IDX_MID    = 7'h7b;
    localparam logic [6:0] ADDR_IDX_LOW    = 7'h7c;
    localparam logic [6:0] ADDR_GRP_HIGH   = 7'h7d;
    localparam logic [6:0] ADDR_GRP_LOW    = 7'h7e;
    localparam logic [6:0] ADDR_STATUS     = 7'h7f;
    localparam logic [6:0] ADDR_DBUF_FIRST = 7'h0c;
    localparam logic [6:0] ADDR_DBUF_LAST  = 7'h0f;
    localparam logic [3:0] BANK_DBUF       = 4'h0;
    // ------------------------------------------------------------------
    // reset values and program memory tops per variant
    // ------------------------------------------------------------------
    localparam logic [15:0] PTR_RESET      = 16'h0000;
    localparam logic [3:0]  NIB_RESET      = 4'h0;
    localparam logic [15:0] PTR_ONE        = 16'h0001;
    localparam logic [15:0] TOP_SMALL      = 16'h1fff;
    localparam logic [15:0] TOP_MIDDLE     = 16'h2fff;
    localparam logic [15:0] TOP_LARGE      = 16'h3fff;
    localparam logic [15:0] PTR_ALL_ONES   = 16'hffff;
    // ------------------------------------------------------------------
    // nibble slicing of the pointer on the data bus
    // ------------------------------------------------------------------
    localparam int          NIB_W          = 4;
    localparam logic [1:0]  NIB_IDX_TOP    = 2'h3;
    localparam logic [3:0]  RDATA_NONE     = 4'h0;
    // ------------------------------------------------------------------
    // pointer operations from the execution unit
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PPAR_OP_NONE,
        PPAR_OP_TBL_READ,
        PPAR_OP_PUSH,
        PPAR_OP_POP,
        PPAR_OP_BRANCH,
        PPAR_OP_CALL,
        PPAR_OP_INC,
        PPAR_OP_CLK_STOP,
        PPAR_OP_DBUF_LOAD,
        PPAR_OP_DBUF_STORE
    } ppar_op_t;
endpackage
`default_nettype wire

/* ppar_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module ppar_regs
    import ppar_pkg::*;
#(
    parameter logic [15:0] PROG_TOP = TOP_LARGE,
    parameter int          SP_W     = 3
) (
    // clock and resets
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic              WDT_STACK_RST,
    input  wire logic              CE_RST,
    // data memory access
    input  wire logic [3:0]        DM_BANK,
    input  wire logic [6:0]        DM_ADDR,
    input  wire logic              DM_WR,
    input  wire logic [3:0]        DM_WDATA,
    output logic      [3:0]        DM_RDATA,
    output logic                   DM_SYSTEM_REGISTER_AREA_HIT,
    output logic                   DM_DBUF_HIT,
    // other system registers, kept outside this block
    input  wire logic [3:0]        OTHER_SYSTEM_REGISTER_AREA_RDATA,
    // instruction execution
    input  wire logic [3:0]        OP,
    input  wire logic              OP_VALID,
    // program memory
    output logic      [15:0]       PM_ADDR,
    output logic                   PM_RD,
    input  wire logic [15:0]       PM_RDATA,
    output logic                   PM_RANGE_ERR,
    // program counter load
    output logic                   PC_LOAD,
    output logic                   PC_CALL,
    output logic      [15:0]       PC_TARGET,
    // stack pointer and address stack
    output logic                   SP_DEC,
    output logic                   SP_INC,
    input  wire logic [SP_W-1:0]   SP,
    output logic                   STK_WR,
    output logic      [SP_W-1:0]   STK_IDX,
    output logic      [15:0]       STK_WDATA,
    input  wire logic [15:0]       STK_RDATA,
    // data buffer
    output logic                   DBUF_WR,
    output logic      [15:0]       DBUF_WDATA,
    input  wire logic [15:0]       DBUF_RDATA,
    // pointer value
    output logic      [15:0]       PTR
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [15:0] ptr_ff;
    logic [15:0] nxt_ptr;
    logic        op_tbl;
    logic        op_push;
    logic        op_pop;
    logic        op_br;
    logic        op_call;
    logic        op_inc;
    logic        op_dld;
    logic        op_dst;
    logic        sys_hit;
    logic [1:0]  nib_sel;
    logic [3:0]  nib_rd;
    logic        any_rst;
    logic        in_range;

    // every check below runs on the core clock and pauses in power-on reset
    default clocking chk_cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    function automatic logic is_op(input logic [3:0] code, input ppar_op_t o);
        is_op = (code == 4'(o));
    endfunction

    // nibble at 74h sits in bits 15:12, the one at 77h in bits 3:0
    function automatic int nib_base(input logic [1:0] sel);
        nib_base = (int'(NIB_IDX_TOP) - int'(sel)) * NIB_W;
    endfunction

    assign op_tbl  = OP_VALID && is_op(OP, PPAR_OP_TBL_READ);
    assign op_push = OP_VALID && is_op(OP, PPAR_OP_PUSH);
    assign op_pop  = OP_VALID && is_op(OP, PPAR_OP_POP);
    assign op_br   = OP_VALID && is_op(OP, PPAR_OP_BRANCH);
    assign op_call = OP_VALID && is_op(OP, PPAR_OP_CALL);
    assign op_inc  = OP_VALID && is_op(OP, PPAR_OP_INC);
    assign op_dld  = OP_VALID && is_op(OP, PPAR_OP_DBUF_LOAD);
    assign op_dst  = OP_VALID && is_op(OP, PPAR_OP_DBUF_STORE);

    // bank bits ignored: the system area answers in every bank
    assign sys_hit = (DM_ADDR >= ADDR_PTR_TOP) && (DM_ADDR <= ADDR_STATUS);
    assign DM_SYSTEM_REGISTER_AREA_HIT = sys_hit;
    assign DM_DBUF_HIT = (DM_BANK == BANK_DBUF) && (DM_ADDR >= ADDR_DBUF_FIRST)
                         && (DM_ADDR <= ADDR_DBUF_LAST);
    assign nib_sel = 2'(DM_ADDR - ADDR_PTR_TOP);
    // 74h carries bits 15:12, 77h bits 3:0
    assign nib_rd  = ptr_ff[nib_base(nib_sel) +: NIB_W];
    assign DM_RDATA = (DM_ADDR <= ADDR_PTR_BOTTOM && sys_hit) ? nib_rd
                    : (sys_hit ? OTHER_SYSTEM_REGISTER_AREA_RDATA : RDATA_NONE);

    // ------------------------------------------------------------------
    // pointer next value
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ptr = ptr_ff; // clock stop and idle keep the value
        if (op_inc) begin
            nxt_ptr = ptr_ff + PTR_ONE; // full carry, ffff wraps silently
        end else if (op_pop) begin
            nxt_ptr = STK_RDATA; // entry at current sp
        end else if (op_dld) begin
            nxt_ptr = DBUF_RDATA; // peripheral exchange
        end else if (DM_WR && sys_hit && DM_ADDR <= ADDR_PTR_BOTTOM) begin
            nxt_ptr[nib_base(nib_sel) +: NIB_W] = DM_WDATA;
        end
    end

    assign any_rst = WDT_STACK_RST || CE_RST;

    // all three resets clear the pointer; the synchronous ones are
    // from core logic on the same clock
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ptr_ff <= PTR_RESET;
        end else if (any_rst) begin
            ptr_ff <= PTR_RESET;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // ------------------------------------------------------------------
    // outputs toward the core
    // ------------------------------------------------------------------
    assign PTR      = ptr_ff;
    // address beyond implemented memory is flagged, not fetched
    assign in_range = (ptr_ff <= PROG_TOP);
    assign PM_ADDR  = ptr_ff;
    assign PM_RD    = op_tbl && in_range;
    assign PM_RANGE_ERR = (op_tbl || op_br || op_call) && !in_range;
    assign DBUF_WR    = (op_tbl && in_range) || op_dst;
    assign DBUF_WDATA = op_tbl ? PM_RDATA : ptr_ff;
    assign PC_LOAD   = (op_br || op_call) && in_range;
    assign PC_CALL   = op_call && in_range;
    assign PC_TARGET = ptr_ff;
    // push writes at sp-1 in the same cycle the sp is decremented
    assign SP_DEC    = op_push;
    assign STK_WR    = op_push;
    assign STK_IDX   = op_push ? SP_W'(SP - 1'b1) : SP;
    assign STK_WDATA = ptr_ff;
    assign SP_INC    = op_pop;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // pointer arithmetic and reset
    a_inc_adds_one: assert property
        (op_inc && !any_rst |=> ptr_ff == 16'($past(ptr_ff) + PTR_ONE))
        else $error("increment wrong");
    a_wrap_zero: assert property
        (op_inc && !any_rst && ptr_ff == PTR_ALL_ONES
         |=> ptr_ff == PTR_RESET)
        else $error("wrap wrong");
    a_reset_clears: assert property
        (any_rst |=> ptr_ff == PTR_RESET)
        else $error("reset did not clear");
    a_stop_holds: assert property
        (OP_VALID && is_op(OP, PPAR_OP_CLK_STOP) && !any_rst && !DM_WR
         |=> $stable(ptr_ff))
        else $error("clock stop changed pointer");
    // stack traffic
    a_pop_loads: assert property
        (op_pop && !any_rst |-> SP_INC && STK_IDX == SP
         ##1 ptr_ff == $past(STK_RDATA))
        else $error("pop wrong");
    a_push_index: assert property
        (op_push |-> STK_WR && SP_DEC && STK_IDX == SP_W'(SP - 1'b1)
         && STK_WDATA == ptr_ff)
        else $error("push wrong");
    // program memory and program counter
    a_tbl_read: assert property
        (op_tbl && ptr_ff <= PROG_TOP |-> PM_RD && DBUF_WR
         && DBUF_WDATA == PM_RDATA && PM_ADDR == ptr_ff)
        else $error("table read wrong");
    a_branch_target: assert property
        ((op_br || op_call) && ptr_ff <= PROG_TOP
         |-> PC_LOAD && PC_TARGET == ptr_ff)
        else $error("branch target wrong");
    a_call_flag: assert property
        ((op_call && ptr_ff <= PROG_TOP |-> PC_CALL)
         and (op_br |-> !PC_CALL))
        else $error("call flag wrong");
    a_range_guard: assert property
        (ptr_ff > PROG_TOP |-> !PM_RD && !PC_LOAD)
        else $error("out of range access");
    a_range_flag: assert property
        ((op_tbl || op_br || op_call) && ptr_ff > PROG_TOP
         |-> PM_RANGE_ERR)
        else $error("range flag missing");
    // data memory view
    a_nib_order: assert property
        (DM_ADDR == ADDR_PTR_TOP |-> DM_RDATA == ptr_ff[15:12])
        else $error("nibble order wrong");
    a_nib_write: assert property
        (DM_WR && DM_ADDR == ADDR_PTR_BOTTOM && !OP_VALID && !any_rst
         |=> ptr_ff[NIB_W-1:0] == $past(DM_WDATA))
        else $error("low nibble write wrong");
    a_other_read: assert property
        (DM_ADDR >= ADDR_WINDOW && DM_ADDR <= ADDR_STATUS
         |-> DM_SYSTEM_REGISTER_AREA_HIT && DM_RDATA == OTHER_SYSTEM_REGISTER_AREA_RDATA)
        else $error("other system register read wrong");
    a_dbuf_window: assert property
        (DM_DBUF_HIT |-> DM_BANK == BANK_DBUF && DM_ADDR >= ADDR_DBUF_FIRST
         && DM_ADDR <= ADDR_DBUF_LAST)
        else $error("data buffer decode wrong");
    // peripheral exchange through the data buffer
    a_dbuf_load: assert property
        (op_dld && !any_rst |=> ptr_ff == $past(DBUF_RDATA))
        else $error("buffer load wrong");
    a_dbuf_store: assert property
        (op_dst |-> DBUF_WR && DBUF_WDATA == ptr_ff)
        else $error("buffer store wrong");
    c_inc: cover property (@(posedge CLK) op_inc ##1 op_inc);
    c_push_pop: cover property (@(posedge CLK) op_push ##[1:16] op_pop);
    c_tbl: cover property (@(posedge CLK) op_tbl && in_range);
    c_wrap: cover property (@(posedge CLK) op_inc && ptr_ff == PTR_ALL_ONES);
    c_range: cover property (@(posedge CLK) PM_RANGE_ERR);
endmodule
`default_nettype wire

/* test_program_address_pointer_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_program_address_pointer_regs;
    import ppar_pkg::*;
    logic        CLK, SYS_RST, WDT_STACK_RST, CE_RST, DM_WR, OP_VALID;
    logic [3:0]  DM_BANK, DM_WDATA, DM_RDATA, OP;
    logic [6:0]  DM_ADDR;
    logic        sys_hit, dbf_hit, pm_rd, rng_err, pc_load, pc_call;
    logic        sp_dec, sp_inc, stk_wr, dbuf_wr;
    logic [2:0]  sp, stk_idx;
    logic [15:0] pm_addr, pm_rdata, pc_tgt, stk_wd, stk_rd;
    logic [15:0] dbuf_wd, DBUF_RDATA, ptr;
    int          n_errors, n_checks, cyc;
    ppar_regs dut (.CLK(CLK), .SYS_RST(SYS_RST), .WDT_STACK_RST(WDT_STACK_RST),
        .CE_RST(CE_RST), .DM_BANK(DM_BANK), .DM_ADDR(DM_ADDR), .DM_WR(DM_WR),
        .DM_WDATA(DM_WDATA), .DM_RDATA(DM_RDATA), .DM_SYSTEM_REGISTER_AREA_HIT(sys_hit),
        .DM_DBUF_HIT(dbf_hit), .OTHER_SYSTEM_REGISTER_AREA_RDATA(4'h9), .OP(OP),
        .OP_VALID(OP_VALID), .PM_ADDR(pm_addr), .PM_RD(pm_rd),
        .PM_RDATA(pm_rdata), .PM_RANGE_ERR(rng_err), .PC_LOAD(pc_load),
        .PC_CALL(pc_call), .PC_TARGET(pc_tgt), .SP_DEC(sp_dec),
        .SP_INC(sp_inc), .SP(sp), .STK_WR(stk_wr), .STK_IDX(stk_idx),
        .STK_WDATA(stk_wd), .STK_RDATA(stk_rd), .DBUF_WR(dbuf_wr),
        .DBUF_WDATA(dbuf_wd), .DBUF_RDATA(DBUF_RDATA), .PTR(ptr));
    ppar_core_model core (.CLK(CLK), .SYS_RST(SYS_RST), .SP_DEC(sp_dec),
        .SP_INC(sp_inc), .STK_WR(stk_wr), .STK_IDX(stk_idx),
        .STK_WDATA(stk_wd), .STK_RDATA(stk_rd), .SP(sp),
        .PM_ADDR(pm_addr), .PM_RDATA(pm_rdata));
    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    // nibble writes leave one idle cycle so the strobe falls between nibbles
    task automatic set_ptr(logic [3:0] b, logic [15:0] v);
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            DM_BANK <= b;
            DM_ADDR <= 7'h74 + 7'(i);
            DM_WDATA <= v[15-4*i -: 4];
            DM_WR <= 1'b1;
            @(posedge CLK);
            DM_WR <= 1'b0;
        end
        #1;
    endtask
    task automatic rd(logic [3:0] b, logic [6:0] a, logic [5:0] e);
        @(posedge CLK);
        DM_BANK <= b;
        DM_ADDR <= a;
        #1;
        chk("read", {10'h0, e}, {10'h0, DM_RDATA, sys_hit, dbf_hit});
    endtask
    task automatic op_go(ppar_op_t o);
        @(posedge CLK);
        OP <= o;
        OP_VALID <= 1'b1;
        #1;
    endtask
    task automatic op_end;
        @(posedge CLK);
        OP_VALID <= 1'b0;
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        chk("ptr_rst", 16'h0, ptr);
        set_ptr(4'h5, 16'h1234);
        chk("ptr_wr", 16'h1234, ptr);
        rd(4'h0, 7'h74, 6'h06);
        rd(4'hf, 7'h77, 6'h12);
        rd(4'h3, 7'h7a, 6'h26);
        rd(4'h0, 7'h0c, 6'h01);
        rd(4'h1, 7'h0f, 6'h00);
        // a write above 77h belongs to another register
        @(posedge CLK);
        DM_ADDR <= 7'h7a;
        DM_WDATA <= 4'hf;
        DM_WR <= 1'b1;
        @(posedge CLK);
        DM_WR <= 1'b0;
        #1;
        chk("wr_7a", 16'h1234, ptr);
    endtask
    task automatic t_flow;
        set_ptr(4'h0, 16'h0fff);
        op_go(PPAR_OP_INC);
        op_go(PPAR_OP_INC);
        chk("inc", 16'h1000, ptr);
        op_end();
        chk("inc2", 16'h1001, ptr);
        set_ptr(4'h2, 16'hffff);
        op_go(PPAR_OP_INC);
        op_end();
        chk("wrap", 16'h0000, ptr);
        // normal loads stay at the top of implemented memory
        set_ptr(4'h0, 16'h3fff);
        op_go(PPAR_OP_TBL_READ);
        chk("tbl_a", 16'h3fff, pm_addr);
        chk("tbl", 16'h7, {13'h0, pm_rd, dbuf_wr, ~rng_err});
        chk("tbl_d", 16'h3fff ^ 16'ha5c3, dbuf_wd);
        op_go(PPAR_OP_BRANCH);
        chk("br", 16'h3fff, pc_load ? pc_tgt : 16'h0);
        chk("br_c", 16'h0, {15'h0, pc_call});
        op_go(PPAR_OP_CALL);
        chk("call", 16'h3, {14'h0, pc_call, pc_load});
        chk("call_t", 16'h3fff, pc_tgt);
        op_end();
        // one deliberate load past the top probes the refusal
        set_ptr(4'h0, 16'h4000);
        op_go(PPAR_OP_CALL);
        chk("range", 16'h4, {13'h0, rng_err, pc_call, pc_load});
        op_go(PPAR_OP_TBL_READ);
        chk("range_t", 16'h4, {13'h0, rng_err, pm_rd, dbuf_wr});
        op_end();
    endtask
    task automatic t_stack;
        set_ptr(4'h0, 16'h1234);
        op_go(PPAR_OP_PUSH);
        chk("push", 16'hf, {12'h0, sp_dec, stk_idx});
        chk("push_d", 16'h1234, stk_wr ? stk_wd : 16'h0);
        op_end();
        set_ptr(4'h0, 16'h0);
        op_go(PPAR_OP_POP);
        chk("pop", 16'hf, {12'h0, sp_inc, stk_idx});
        op_end();
        chk("pop_v", 16'h1234, ptr);
        chk("sp", 16'h0, {13'h0, sp});
        op_go(PPAR_OP_CLK_STOP);
        op_end();
        chk("stop", 16'h1234, ptr);
        @(posedge CLK);
        DBUF_RDATA <= 16'h2468;
        op_go(PPAR_OP_DBUF_LOAD);
        op_end();
        chk("ld", 16'h2468, ptr);
        op_go(PPAR_OP_DBUF_STORE);
        chk("st", 16'h2468, dbuf_wr ? dbuf_wd : 16'h0);
        op_end();
    endtask
    task automatic t_sync_rst;
        for (int i = 0; i < 2; i++) begin
            set_ptr(4'h0, 16'h3c5a);
            @(posedge CLK);
            {WDT_STACK_RST, CE_RST} <= i ? 2'b01 : 2'b10;
            @(posedge CLK);
            {WDT_STACK_RST, CE_RST} <= 2'b00;
            #1;
            chk("srst", 16'h0, ptr);
        end
        // a synchronous reset beats an increment taken at the same edge
        set_ptr(4'h0, 16'h0fff);
        @(posedge CLK);
        OP <= PPAR_OP_INC;
        OP_VALID <= 1'b1;
        CE_RST <= 1'b1;
        @(posedge CLK);
        {OP_VALID, CE_RST} <= 2'b00;
        #1;
        chk("rst_op", 16'h0, ptr);
        // power-on reset in mid-run clears at once, then ops resume
        set_ptr(4'h0, 16'h3c5a);
        @(posedge CLK);
        SYS_RST <= 1'b1;
        #1;
        chk("arst", 16'h0, ptr);
        @(posedge CLK);
        SYS_RST <= 1'b0;
        op_go(PPAR_OP_INC);
        op_end();
        chk("arst_inc", 16'h1, ptr);
    endtask
    initial begin
        CLK = 0;
        forever #4 CLK = ~CLK;
    end
    // hang guard: the whole sequence needs about 130 cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 1000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        {SYS_RST, WDT_STACK_RST, CE_RST, DM_WR, OP_VALID} = 5'b10000;
        {DM_BANK, DM_WDATA, OP, DM_ADDR, DBUF_RDATA} = '0;
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_regs();
        t_flow();
        t_stack();
        t_sync_rst();
        final_report();
    end
endmodule
`default_nettype wire
